//--- common/pcir_pkg.sv
// pcir_pkg: constants for the clock generator id and pump control registers.
// assumes a serial-port front end on the same clock that issues byte
// accesses with a 10-bit register address.
// ============================================================
// Overview of operation
// [R1] 8-bit read-only register returns a fixed variant identifier code.
// [R2] readback selector bit 0: 0 reads buffered copies, 1 reads active values.
// [R3] 16-bit version tag: low byte lower address, high byte next; both reset 0.
// [R4] version tag bytes are storage only and steer nothing.
// [R5] polarity bit 7: 0 positive, 1 negative; host keeps 0 with internal VCO.
// [R6] pump code bits 6:4 pick 0.6 mA steps, 0.6 mA at 000 up.
// [R7] writes to the variant identifier are ignored.
package pcir_pkg;
  localparam int          ADDR_W            = 10;
  localparam int          DATA_W            = 8;
  localparam int          CURR_W            = 6;
  // ==========================================================
  // register offsets
  localparam logic [9:0]  OFS_VARIANT_ID    = 10'h003;
  localparam logic [9:0]  OFS_READBACK_SEL  = 10'h004;
  localparam logic [9:0]  OFS_TAG_LOW       = 10'h005;
  localparam logic [9:0]  OFS_TAG_HIGH      = 10'h006;
  localparam logic [9:0]  OFS_PUMP_CTRL     = 10'h010;
  // ==========================================================
  // field positions
  localparam int          POS_READBACK_SEL  = 0;
  localparam int          POS_SENSE         = 7;
  localparam int          POS_PUMP_CODE_HI  = 6;
  localparam int          POS_PUMP_CODE_LO  = 4;
  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_READBACK_SEL  = 8'h00;
  localparam logic [7:0]  RST_TAG           = 8'h00;
  // positive sense, code 111, normal pump mode, asynchronous power-down
  localparam logic [7:0]  RST_PUMP_CTRL     = 8'h7D;
  localparam logic [7:0]  RD_UNMAPPED       = 8'h00;
  // code 111 after reset: eight steps of 0.6 mA, in 0.1 mA units
  localparam logic [5:0]  RST_PUMP_CURRENT  = 6'h30;
  // pump current is reported in units of 0.1 mA, 6 units per code step
  localparam logic [5:0]  CURR_STEP_UNITS   = 6'h06;
endpackage

//--- hw/pcir_pump_decode.sv
// pcir_pump_decode: maps the 3-bit pump current code to a current figure.
// assumes a registered code input; the output is combinational.
`timescale 1ns/1ps
`default_nettype none
module pcir_pump_decode
  import pcir_pkg::*;
(
  input  wire logic [2:0]  code_i,
  output logic      [5:0]  current_o
);
  // (code + 1) steps of 0.6 mA, in 0.1 mA units: 6 .. 48
  wire logic [5:0] code_plus_one = {3'h0, code_i} + 6'h01;

  assign current_o = 6'(code_plus_one * CURR_STEP_UNITS); // R6
endmodule
`default_nettype wire

//--- hw/pcir_regs.sv
// pcir_regs: variant id, readback select, user version tag and the phase
// detector / pump control register, with buffered and active copies.
// assumes byte accesses from a serial-port engine on CORE_CLK_I; tag and pump
// writes land in the buffer copy and UPDATE_I copies buffers into the active set.
`timescale 1ns/1ps
`default_nettype none
module pcir_regs
  import pcir_pkg::*;
#(
  // arbitrary neutral value, not a real part code
  parameter logic [7:0] VARIANT_CODE = 8'h5A
)
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [9:0]  ADDR_I,
  input  wire logic [7:0]  WR_DATA_I,
  input  wire logic        WR_EN_I,
  input  wire logic        RD_EN_I,
  input  wire logic        UPDATE_I,
  output logic      [7:0]  RD_DATA_O,
  output logic             RD_VALID_O,
  output logic             SENSE_NEG_O,
  output logic      [2:0]  PUMP_CODE_O,
  output logic      [5:0]  PUMP_CURRENT_O
);
  // ==========================================================
  // storage
  logic [7:0] readback_sel;
  logic [7:0] tag_low_buf;
  logic [7:0] tag_high_buf;
  logic [7:0] pump_buf;
  logic [7:0] tag_low_act;
  logic [7:0] tag_high_act;
  logic [7:0] pump_act;

  // ==========================================================
  // address decode
  wire logic hit_variant = (ADDR_I == OFS_VARIANT_ID);
  wire logic hit_sel     = (ADDR_I == OFS_READBACK_SEL);
  wire logic hit_low     = (ADDR_I == OFS_TAG_LOW);
  wire logic hit_high    = (ADDR_I == OFS_TAG_HIGH);
  wire logic hit_pump    = (ADDR_I == OFS_PUMP_CTRL);
  wire logic read_active = readback_sel[POS_READBACK_SEL];

  // ==========================================================
  // read selection
  wire logic [7:0] low_view  = read_active ? tag_low_act : tag_low_buf;
  wire logic [7:0] high_view = read_active ? tag_high_act : tag_high_buf;
  wire logic [7:0] pump_view = read_active ? pump_act : pump_buf; // R2
  wire logic [7:0] next_rd_data =
    hit_variant ? VARIANT_CODE :                      // R1
    hit_sel     ? readback_sel :
    hit_low     ? low_view     :                      // R3
    hit_high    ? high_view    :
    hit_pump    ? pump_view    : RD_UNMAPPED;

  // ==========================================================
  // pump decode from the active copy only
  wire logic [2:0] act_code = pump_act[POS_PUMP_CODE_HI:POS_PUMP_CODE_LO];
  wire logic [5:0] act_current;

  pcir_pump_decode u_decode (
    .code_i    (act_code),
    .current_o (act_current)
  );

  // ==========================================================
  // buffer writes; the variant id has no storage so writes fall away
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      readback_sel <= RST_READBACK_SEL;
      tag_low_buf  <= RST_TAG;
      tag_high_buf <= RST_TAG;
      pump_buf     <= RST_PUMP_CTRL;
    end else if (WR_EN_I) begin
      // selector acts at once so a host can check what it just wrote
      if (hit_sel) readback_sel <= {7'h00, WR_DATA_I[POS_READBACK_SEL]}; // R2
      if (hit_low) tag_low_buf <= WR_DATA_I;   // R3
      if (hit_high) tag_high_buf <= WR_DATA_I; // R3
      if (hit_pump) pump_buf <= WR_DATA_I;     // R5
    end
  end

  // ==========================================================
  // transfer of buffers into the active set
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tag_low_act  <= RST_TAG;
      tag_high_act <= RST_TAG;
      pump_act     <= RST_PUMP_CTRL;
    end else if (UPDATE_I) begin
      tag_low_act  <= tag_low_buf;
      tag_high_act <= tag_high_buf;
      pump_act     <= pump_buf;
    end
  end

  // ==========================================================
  // registered outputs; the tag reaches only RD_DATA_O through reads, never the pump outputs
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_DATA_O      <= RD_UNMAPPED;
      RD_VALID_O     <= 1'b0;
      SENSE_NEG_O    <= 1'b0;
      PUMP_CODE_O    <= RST_PUMP_CTRL[POS_PUMP_CODE_HI:POS_PUMP_CODE_LO];
      PUMP_CURRENT_O <= RST_PUMP_CURRENT;
    end else begin
      RD_VALID_O     <= RD_EN_I;
      if (RD_EN_I) RD_DATA_O <= next_rd_data;
      SENSE_NEG_O    <= pump_act[POS_SENSE];  // R5
      PUMP_CODE_O    <= act_code;             // R6
      PUMP_CURRENT_O <= act_current;          // R6 R4
    end
  end

  // ==========================================================
  // checks
  variant_read_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    RD_EN_I && hit_variant |=> RD_DATA_O == VARIANT_CODE) // R1
    else $error("variant identifier read returned wrong code");

  variant_write_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    WR_EN_I && hit_variant ##2 RD_EN_I && hit_variant
      |=> RD_DATA_O == VARIANT_CODE) // R7
    else $error("variant identifier changed by a write");

  readback_buf_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    RD_EN_I && hit_pump && !read_active |=> RD_DATA_O == $past(pump_buf)) // R2
    else $error("buffered readback did not return buffer copy");

  readback_act_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    RD_EN_I && hit_high && read_active
      |=> RD_DATA_O == $past(tag_high_act)) // R2
    else $error("active readback did not return active copy");

  tag_store_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    WR_EN_I && hit_low ##1 !(WR_EN_I && hit_low)
      ##1 RD_EN_I && hit_low && !read_active && !WR_EN_I
      |=> RD_DATA_O == $past(WR_DATA_I, 3)) // R3
    else $error("version tag low byte not stored");

  tag_inert_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    WR_EN_I && (hit_low || hit_high) && !$past(UPDATE_I) && !UPDATE_I
      |=> ##1 $stable(SENSE_NEG_O) && $stable(PUMP_CURRENT_O)) // R4
    else $error("version tag write disturbed pump outputs");

  sense_follow_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    UPDATE_I |=> ##1 SENSE_NEG_O == $past(pump_buf[POS_SENSE], 2)) // R5
    else $error("phase detector sense did not follow update");

  pump_current_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    PUMP_CURRENT_O == 6'(({3'h0, PUMP_CODE_O} + 6'h01) * 6'h06)) // R6
    else $error("pump current figure does not match code");

  // ==========================================================
  // read port handshake
  // every read strobe gets exactly one valid pulse one cycle later
  valid_pulse_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    RD_EN_I |=> RD_VALID_O)
    else $error("read strobe not answered by valid pulse");

  // valid must never appear without a read strobe behind it
  valid_idle_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    !RD_EN_I |=> !RD_VALID_O)
    else $error("valid pulse without read strobe");

  // hosts may sample read data late, so it holds until the next read
  rd_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    !RD_EN_I |=> $stable(RD_DATA_O))
    else $error("read data changed without a read");

  // holes in the map answer with a fixed pattern, never stale data
  unmapped_read_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    RD_EN_I && !(hit_variant || hit_sel || hit_low || hit_high || hit_pump)
      |=> RD_DATA_O == RD_UNMAPPED)
    else $error("unmapped read returned nonzero data");

  // ==========================================================
  // storage and transfer
  // the selector keeps only its one defined bit
  sel_write_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    WR_EN_I && hit_sel
      |=> readback_sel == {7'h00, $past(WR_DATA_I[POS_READBACK_SEL])}) // R2
    else $error("readback selector not stored");

  // high byte is independent of the low byte
  tag_high_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    WR_EN_I && hit_high |=> tag_high_buf == $past(WR_DATA_I)) // R3
    else $error("version tag high byte not stored");

  // all buffered registers move together on one update
  update_copy_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    UPDATE_I |=> tag_low_act == $past(tag_low_buf)
      && tag_high_act == $past(tag_high_buf)
      && pump_act == $past(pump_buf)) // R3
    else $error("update did not copy buffers into active set");

  // buffer writes alone must never leak into the active set
  act_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    !UPDATE_I |=> $stable(pump_act) && $stable(tag_low_act)
      && $stable(tag_high_act)) // R4
    else $error("active set changed without update");

  // ==========================================================
  // pump outputs
  // the code output lags the update by the active copy and output stage
  code_follow_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    UPDATE_I |=> ##1 PUMP_CODE_O
      == $past(pump_buf[POS_PUMP_CODE_HI:POS_PUMP_CODE_LO], 2)) // R6
    else $error("pump code did not follow update");

  // the figure spans one to eight steps of 0.6 mA
  current_range_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    PUMP_CURRENT_O >= 6'h06 && PUMP_CURRENT_O <= 6'h30) // R6
    else $error("pump current figure out of range");

  // sense follows only the active copy, never a fresh buffer write
  sense_hold_a: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_N_I)
    !UPDATE_I ##1 !UPDATE_I |=> $stable(SENSE_NEG_O)) // R5
    else $error("phase detector sense changed without update");
endmodule
`default_nettype wire

//--- verif/pcir_host.sv
// pcir_host: serial-port host model issuing byte accesses to pcir_regs.
// assumes the register block samples its strobes at rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module pcir_host
  import pcir_pkg::*;
#(
  parameter bit EXT_VCO = 1'b1
)
(
  input  wire logic       clk_i,
  output logic      [9:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            we_o,
  output logic            re_o,
  output logic            upd_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  initial begin
    addr_o  = 10'h000;
    wdata_o = 8'h00;
    we_o    = 1'b0;
    re_o    = 1'b0;
    upd_o   = 1'b0;
  end
  // ==========================================================
  // accesses: strobes rise one edge before the taking edge and drop on it
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    // negative sense only with an external oscillator
    wdata_o <= (a == OFS_PUMP_CTRL && !EXT_VCO) ? (d & 8'h7F) : d;
    we_o    <= 1'b1;
    @(posedge clk_i);
    we_o    <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk_i);
    addr_o <= a;
    re_o   <= 1'b1;
    @(posedge clk_i);
    re_o   <= 1'b0;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
  task automatic upd();
    @(posedge clk_i);
    upd_o <= 1'b1;
    @(posedge clk_i);
    upd_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// tb_top: register sequences against pcir_regs through the host model.
// assumes the design's reset values and one-cycle read answer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcir_pkg::*;
  // arbitrary neutral code
  localparam logic [7:0] VID = 8'h3C;
  logic       clk, rst_n, we, re, upd, rvalid, sense;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [2:0] code;
  logic [5:0] cur;
  logic       v;
  int         failures, n_compared;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  pcir_regs #(.VARIANT_CODE(VID)) i_dut (.CORE_CLK_I(clk),
    .RST_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_EN_I(we),
    .RD_EN_I(re), .UPDATE_I(upd), .RD_DATA_O(rdata), .RD_VALID_O(rvalid),
    .SENSE_NEG_O(sense), .PUMP_CODE_O(code), .PUMP_CURRENT_O(cur));
  pcir_host #(.EXT_VCO(1'b1)) i_host (.clk_i(clk), .addr_o(addr),
    .wdata_o(wdata), .we_o(we), .re_o(re), .upd_o(upd),
    .rdata_i(rdata), .rvalid_i(rvalid));
  // ==========================================================
  // compare helpers
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [7:0] e,
                       input string nm);
    i_host.rd(a, d, v);
    chk("rd_valid", {7'h00, v}, 8'h01);
    chk(nm, d, e);
  endtask
  task automatic pump(input logic s, input logic [2:0] c);
    chk("sense", {7'h00, sense}, {7'h00, s});
    chk("code", {5'h00, code}, {5'h00, c});
    chk("current", {2'h0, cur}, {5'h00, c} * 8'h06 + 8'h06);
  endtask
  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog and sequence
  initial begin
    #(4000 * 50);
    failures++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    pump(1'b0, 3'h7);
    rdchk(OFS_READBACK_SEL, 8'h00, "sel");
    rdchk(OFS_TAG_LOW, 8'h00, "tag_lo");
    rdchk(OFS_TAG_HIGH, 8'h00, "tag_hi");
    rdchk(OFS_VARIANT_ID, VID, "variant");
    i_host.wr(OFS_VARIANT_ID, 8'hFF);
    rdchk(OFS_VARIANT_ID, VID, "variant_wr");
    i_host.wr(OFS_TAG_LOW, 8'h34);
    i_host.wr(OFS_TAG_HIGH, 8'h12);
    i_host.upd();
    rdchk(OFS_TAG_LOW, 8'h34, "tag_lo");
    rdchk(OFS_TAG_HIGH, 8'h12, "tag_hi");
    pump(1'b0, 3'h7);
    for (int c = 0; c < 8; c++) begin
      i_host.wr(OFS_PUMP_CTRL, {c[0], c[2:0], 4'hD});
      rdchk(OFS_PUMP_CTRL, {c[0], c[2:0], 4'hD}, "pump_buf");
      i_host.upd();
      pump(c[0], c[2:0]);
    end
    i_host.wr(OFS_PUMP_CTRL, 8'h2D);
    rdchk(OFS_PUMP_CTRL, 8'h2D, "buf_view");
    i_host.wr(OFS_READBACK_SEL, 8'h01);
    rdchk(OFS_PUMP_CTRL, 8'hFD, "act_view");
    rdchk(OFS_READBACK_SEL, 8'h01, "sel");
    rdchk(10'h3FF, RD_UNMAPPED, "unmapped");
    wrap_up();
  end
endmodule
`default_nettype wire
